// file: hdl/corr_ctrl_defines.svh
// corr_ctrl_defines.svh: timing counts and fixed values for the correlator control block
// assumes: included by bare name from the design module
`ifndef CORR_CTRL_DEFINES_SVH
`define CORR_CTRL_DEFINES_SVH
// ----------------------------------------------------------------
// frame timing
// ----------------------------------------------------------------
`define FRAME_UNIT_SAMPLES 32'd125000
`define FRAME_MULT_MAX 9'd256
`define FRAME_PULSE_LEN 9'd256
// ----------------------------------------------------------------
// strobe exponents
// ----------------------------------------------------------------
`define STROBE_EXP_MAX 3'd7
// ----------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------
`define SRC_FORMATTER 2'h0
`define SRC_TRACK_A 2'h1
`define SRC_TRACK_B 2'h2
`endif

// file: hdl/corr_ctrl_pkg.sv
// corr_ctrl_pkg.sv: types shared by the correlator control block
// assumes: the defines header sits beside it
package corr_ctrl_pkg;
  // ----------------------------------------------------------------
  // function of the block
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_CORRELATE,
    MODE_CAPTURE
  } use_mode_e;
endpackage : corr_ctrl_pkg

// file: hdl/correlator_control_timing.sv
// correlator_control_timing.sv: frame, accumulate and shift strobes for the correlator chip,
// with source selection and sample-stream routing to the four-way multiplexer inputs.
// assumes: ref_clk at 40 MHz oversamples every sample clock and tick; config inputs are
// quasi-static levels from the processor on the same clock.
//
// Contract
// - frame pulse period is n times 125000 samples
// - frame pulse lasts 256 sample clocks
// - accumulate strobe one clock, period 2^n
// - accumulate strobe high first sample after frame
// - shift strobe one clock, period 2^n
// - shift strobe high first sample after frame
// - sync errors never shorten a frame
// - frames realign to an arriving second tick
// - frames flywheel when no tick arrives
// - formatter: four 2-bit channels with tick
// - all four formatter channels processed together
// - track bit may replace first sideband channel
// - track mode holds magnitude bit constant
// - track input handled up to 16 Mbit/s
// - count only delivered track clock edges
// - one track decoder feeds correlator at once
// - correlator and capture buffer never together
// - state counting routes one stream to all
`timescale 1ns/1ps
`include "corr_ctrl_defines.svh"

module correlator_control_timing #(
  parameter int UNIT_SAMPLES = 125000,
  parameter int PULSE_LEN = 256
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // formatter source (asynchronous pins)
  input wire logic fmt_clk,
  input wire logic fmt_second_tick,
  input wire logic [7:0] fmt_data,
  // track decoders (asynchronous pins)
  input wire logic trk_a_clk,
  input wire logic trk_a_data,
  input wire logic trk_a_second_tick,
  input wire logic trk_b_clk,
  input wire logic trk_b_data,
  input wire logic trk_b_second_tick,
  // configuration from processor
  input wire logic [1:0] source_sel,
  input wire logic [7:0] frame_mult_m1,
  input wire logic [2:0] add_exp,
  input wire logic [2:0] shift_exp,
  input wire logic magnitude_level,
  input wire logic state_count,
  input wire logic [1:0] state_route,
  input wire logic correlate_req,
  input wire logic capture_req,
  // correlator side
  output logic [7:0] mux_data,
  output logic [3:0] mux_valid,
  output logic frame_start_pulse,
  output logic accumulate_enable,
  output logic shift_enable,
  output logic sample_strobe,
  output logic capture_grant,
  output logic frame_done
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [13:0] meta_ff;
  logic [13:0] sync_ff;
  // tick and clock pins settle through two flops before anyone looks
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_ff <= 14'h0000;
      sync_ff <= 14'h0000;
    end else begin
      meta_ff <= {fmt_clk, fmt_second_tick, fmt_data, trk_a_clk, trk_a_data, trk_a_second_tick, trk_b_clk};
      sync_ff <= meta_ff;
    end
  end
  logic [2:0] trkb_meta_ff;
  logic [2:0] trkb_sync_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trkb_meta_ff <= 3'h0;
      trkb_sync_ff <= 3'h0;
    end else begin
      trkb_meta_ff <= {trk_b_data, trk_b_second_tick, 1'b0};
      trkb_sync_ff <= trkb_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic sel_clk;
  logic sel_tick;
  logic sel_bit;
  logic use_track;
  // only one decoder is routed at a time; the other is simply ignored
  always_comb begin
    use_track = 1'b0;
    sel_clk = sync_ff[13];
    sel_tick = sync_ff[12];
    sel_bit = 1'b0;
    case (source_sel)
      `SRC_TRACK_A: begin
        use_track = 1'b1;
        sel_clk = sync_ff[3];
        sel_tick = sync_ff[1];
        sel_bit = sync_ff[2];
      end
      `SRC_TRACK_B: begin
        use_track = 1'b1;
        sel_clk = sync_ff[0];
        sel_tick = trkb_sync_ff[1];
        sel_bit = trkb_sync_ff[2];
      end
      default: begin
        use_track = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sample edge and tick edge detection
  // ----------------------------------------------------------------
  logic clk_d_ff;
  logic tick_d_ff;
  logic tick_seen_ff;
  logic sample_edge;
  logic tick_edge;
  // a stopped track clock gives no edges, so parity gaps are skipped naturally
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_d_ff <= 1'b0;
      tick_d_ff <= 1'b0;
    end else begin
      clk_d_ff <= sel_clk;
      tick_d_ff <= sel_tick;
    end
  end
  assign sample_edge = sel_clk & ~clk_d_ff;
  assign tick_edge = sel_tick & ~tick_d_ff;

  // tick is latched until the next sample edge, which is where it takes effect
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_seen_ff <= 1'b0;
    end else if (tick_edge) begin
      tick_seen_ff <= 1'b1; // set wins over the clear
    end else if (sample_edge) begin
      tick_seen_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode arbitration
  // ----------------------------------------------------------------
  corr_ctrl_pkg::use_mode_e mode_ff;
  logic run;
  // correlator and capture buffer exclude each other; a held mode keeps the grant
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_ff <= corr_ctrl_pkg::MODE_IDLE;
    end else begin
      case (mode_ff)
        corr_ctrl_pkg::MODE_IDLE: begin
          if (correlate_req) begin
            mode_ff <= corr_ctrl_pkg::MODE_CORRELATE;
          end else if (capture_req) begin
            mode_ff <= corr_ctrl_pkg::MODE_CAPTURE;
          end
        end
        corr_ctrl_pkg::MODE_CORRELATE: begin
          if (!correlate_req) begin
            mode_ff <= corr_ctrl_pkg::MODE_IDLE;
          end
        end
        corr_ctrl_pkg::MODE_CAPTURE: begin
          if (!capture_req) begin
            mode_ff <= corr_ctrl_pkg::MODE_IDLE;
          end
        end
        default: begin
          mode_ff <= corr_ctrl_pkg::MODE_IDLE;
        end
      endcase
    end
  end
  assign run = (mode_ff == corr_ctrl_pkg::MODE_CORRELATE);

  // ----------------------------------------------------------------
  // frame counter
  // ----------------------------------------------------------------
  logic [25:0] frame_cnt_ff;
  logic [25:0] frame_last;
  logic [25:0] stretch_ff;
  logic frame_wrap;
  logic realign_ff;
  logic tick_take;
  // period is (m+1) * unit samples; multiplier input is n-1 so n spans 1..256
  assign frame_last = 26'((32'(frame_mult_m1) + 32'd1) * 32'(UNIT_SAMPLES) - 32'd1);
  assign frame_wrap = (frame_cnt_ff >= frame_last + stretch_ff);
  // one off-boundary tick per frame is taken, which bounds the stretch to one period
  assign tick_take = sample_edge && tick_seen_ff && !realign_ff && (frame_cnt_ff != 26'h0000000);

  // an off-boundary tick stretches the running frame so the next one starts a full period
  // after the tick: realigned, yet never short; a tick on a true boundary costs nothing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      realign_ff <= 1'b0;
      stretch_ff <= 26'h0000000;
    end else if (!run) begin
      realign_ff <= 1'b0;
      stretch_ff <= 26'h0000000;
    end else if (tick_take) begin
      realign_ff <= 1'b1;
      stretch_ff <= frame_cnt_ff;
    end else if (sample_edge && frame_wrap) begin
      realign_ff <= 1'b0;
      stretch_ff <= 26'h0000000;
    end
  end

  // frames flywheel at the programmed period when no tick comes; a taken tick stretches the running frame
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frame_cnt_ff <= 26'h0000000;
    end else if (!run) begin
      frame_cnt_ff <= 26'h0000000;
    end else if (sample_edge) begin
      if (frame_wrap && !tick_take) begin
        frame_cnt_ff <= 26'h0000000;
      end else begin
        frame_cnt_ff <= frame_cnt_ff + 26'h0000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // strobes
  // ----------------------------------------------------------------
  logic [6:0] add_cnt_ff;
  logic [6:0] shift_cnt_ff;
  logic pulse_end;

  function automatic logic [6:0] exp_mask(input logic [2:0] e);
    exp_mask = 7'((8'h01 << e) - 8'h01);
  endfunction

  // first sample after the pulse falls is frame count PULSE_LEN; phase counters load 1 there, so that sample is phase zero
  assign pulse_end = (frame_cnt_ff == 26'(PULSE_LEN));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      add_cnt_ff <= 7'h00;
      shift_cnt_ff <= 7'h00;
    end else if (!run) begin
      add_cnt_ff <= 7'h00;
      shift_cnt_ff <= 7'h00;
    end else if (sample_edge) begin
      add_cnt_ff <= pulse_end ? 7'h01 : (add_cnt_ff + 7'h01) & exp_mask(add_exp);
      shift_cnt_ff <= pulse_end ? 7'h01 : (shift_cnt_ff + 7'h01) & exp_mask(shift_exp);
    end
  end

  // outputs present the state of the sample just taken; n=0 gives a mask of zero, always high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frame_start_pulse <= 1'b0;
      accumulate_enable <= 1'b0;
      shift_enable <= 1'b0;
      sample_strobe <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      sample_strobe <= run & sample_edge;
      frame_done <= run & sample_edge & frame_wrap & !tick_take;
      if (!run) begin
        frame_start_pulse <= 1'b0;
        accumulate_enable <= 1'b0;
        shift_enable <= 1'b0;
      end else if (sample_edge) begin
        frame_start_pulse <= (frame_cnt_ff < 26'(PULSE_LEN));
        accumulate_enable <= pulse_end || ((add_cnt_ff & exp_mask(add_exp)) == 7'h00);
        shift_enable <= pulse_end || ((shift_cnt_ff & exp_mask(shift_exp)) == 7'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // sample routing to the multiplexer inputs
  // ----------------------------------------------------------------
  // data[2k+1] sign, data[2k] magnitude for channel k; channel 0 is the first sideband
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mux_data <= 8'h00;
      mux_valid <= 4'h0;
      capture_grant <= 1'b0;
    end else begin
      capture_grant <= (mode_ff == corr_ctrl_pkg::MODE_CAPTURE);
      if (sample_edge) begin
        if (state_count) begin
          mux_data <= {4{sync_ff[11:10]}};
          mux_valid <= 4'h1 << sync_ff[11:10];
        end else if (use_track) begin
          mux_data <= {sync_ff[9:4], sel_bit, magnitude_level};
          mux_valid <= 4'h1;
        end else begin
          mux_data <= sync_ff[11:4];
          mux_valid <= 4'hF;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pulse_falls;
    sample_strobe && $fell(frame_start_pulse);
  endsequence

  AST_STROBES_AFTER_FRAME: assert property (@(posedge ref_clk) disable iff (reset)
    s_pulse_falls |-> accumulate_enable && shift_enable)
    else $error("strobes not high after frame pulse fell");
  AST_PULSE_ON_WRAP: assert property (@(posedge ref_clk) disable iff (reset)
    frame_done |-> ##[1:64] frame_start_pulse)
    else $error("frame pulse missing after wrap");
  AST_CONT_ADD: assert property (@(posedge ref_clk) disable iff (reset)
    sample_strobe && add_exp == 3'h0 && $stable(add_exp) |-> accumulate_enable)
    else $error("accumulate not continuous at n zero");
  AST_CONT_SHIFT: assert property (@(posedge ref_clk) disable iff (reset)
    sample_strobe && shift_exp == 3'h0 && $stable(shift_exp) |-> shift_enable)
    else $error("shift not continuous at n zero");
  AST_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (reset)
    !(capture_grant && frame_start_pulse))
    else $error("capture and correlator active together");
  AST_NO_EDGE_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !sample_edge && run |=> $stable(frame_cnt_ff))
    else $error("frame count moved without a sample edge");
  AST_NO_SHORT_FRAME: assert property (@(posedge ref_clk) disable iff (reset)
    run && sample_edge && !frame_wrap |=> frame_cnt_ff == $past(frame_cnt_ff) + 26'h0000001)
    else $error("frame cut short");
  AST_MAG_HELD: assert property (@(posedge ref_clk) disable iff (reset)
    sample_edge && use_track && !state_count |=> mux_data[0] == $past(magnitude_level))
    else $error("magnitude bit not held");
endmodule : correlator_control_timing

// file: testbench/sample_source.sv
// sample_source.sv: behavioural far-side sample source, formatter or track decoder
// assumes: bench drives run and tick_req; link clock is 200 ns while run is high
`timescale 1ns/1ps
module sample_source #(
  parameter int GAP = 0
) (
  // control from bench
  input wire logic run,
  input wire logic tick_req,
  // link pins
  output logic clk,
  output logic [7:0] data,
  output logic tick
);
  int k = 0;
  initial begin
    clk = 1'b0;
    data = 8'h00;
    tick = 1'b0;
  end
  // clock stands still when idle; a gap slot drops its rising edge (parity bit)
  always begin
    #3;
    if (run) begin
      clk = !(GAP != 0 && k % GAP == GAP - 1);
      #100;
      clk = 1'b0;
      data = data + 8'h5B; // changes every bit so stale values never match
      k++;
      #97;
    end else begin
      #97;
    end
  end
  // tick only on request, so it is absent unless a scenario asks for it
  always @(posedge tick_req) begin
    tick = 1'b1;
    #400;
    tick = 1'b0;
  end
endmodule : sample_source

// file: testbench/tb.sv
// tb.sv: self-checking bench for the correlator control timing block
// assumes: shortened frame unit and pulse length; sources are sample_source models
`timescale 1ns/1ps
module tb;
  localparam int UNIT = 16;
  localparam int PLEN = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] source_sel = 2'h0;
  logic [7:0] frame_mult_m1 = 8'h01;
  logic [2:0] add_exp = 3'h2;
  logic [2:0] shift_exp = 3'h0;
  logic magnitude_level = 1'b0;
  logic state_count = 1'b0;
  logic correlate_req = 1'b0;
  logic capture_req = 1'b0;
  logic [2:0] run = 3'h0;
  logic [2:0] tick_req = 3'h0;
  logic f_c, a_c, b_c, f_t, a_t, b_t;
  logic [7:0] f_d, a_d, b_d, mux_data;
  logic [3:0] mux_valid;
  logic frame_start_pulse, accumulate_enable, shift_enable, sample_strobe, capture_grant, frame_done;
  int n_errors = 0, checks_done = 0, n_edge = 0, n_add = 0, n_shf = 0, n_done = 0, n_samp = 0;
  int rises = 0, e_r = 0, a_r = 0, s_r = 0, d_r = 0, e_t = -1;
  bit after_t = 0;
  logic pulse_d = 1'b0;
  bit chk = 0;
  wire logic sel_clk = source_sel == 2'h1 ? a_c : (source_sel == 2'h2 ? b_c : f_c);
  always #12.5 ref_clk = !ref_clk;
  sample_source i_fmt (.run(run[0]), .tick_req(tick_req[0]), .clk(f_c), .data(f_d), .tick(f_t));
  sample_source #(.GAP(5)) i_trk_a (.run(run[1]), .tick_req(tick_req[1]), .clk(a_c), .data(a_d), .tick(a_t));
  sample_source i_trk_b (.run(run[2]), .tick_req(tick_req[2]), .clk(b_c), .data(b_d), .tick(b_t));
  correlator_control_timing #(.UNIT_SAMPLES(UNIT), .PULSE_LEN(PLEN)) i_dut (.ref_clk(ref_clk), .reset(reset),
    .fmt_clk(f_c), .fmt_second_tick(f_t), .fmt_data(f_d), .trk_a_clk(a_c), .trk_a_data(a_d[0]),
    .trk_a_second_tick(a_t), .trk_b_clk(b_c), .trk_b_data(b_d[0]), .trk_b_second_tick(b_t),
    .source_sel(source_sel), .frame_mult_m1(frame_mult_m1), .add_exp(add_exp), .shift_exp(shift_exp),
    .magnitude_level(magnitude_level), .state_count(state_count), .state_route(2'h0),
    .correlate_req(correlate_req), .capture_req(capture_req), .mux_data(mux_data), .mux_valid(mux_valid),
    .frame_start_pulse(frame_start_pulse), .accumulate_enable(accumulate_enable), .shift_enable(shift_enable),
    .sample_strobe(sample_strobe), .capture_grant(capture_grant), .frame_done(frame_done));
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic tick1();
    @(posedge ref_clk);
    #1;
  endtask : tick1
  // frame checks are paused while config moves, then rebased at the next frame start
  task automatic setup(input logic [1:0] sel, input logic [7:0] m, input logic [2:0] ae, input logic [2:0] se);
    tick1();
    chk = 0;
    source_sel = sel;
    frame_mult_m1 = m;
    add_exp = ae;
    shift_exp = se;
    repeat (40) tick1();
    rises = 0;
    chk = 1;
  endtask : setup
  task automatic wait_frames(input int n);
    int w;
    w = 0;
    while (rises < n && w < 5000) begin
      @(negedge ref_clk);
      w++;
    end
    check(w < 5000, 1);
  endtask : wait_frames
  task automatic next_samp();
    int w;
    w = 0;
    do begin
      @(negedge ref_clk);
      w++;
    end while (sample_strobe !== 1'b1 && w < 100);
  endtask : next_samp
  // per-frame monitor: period and pulse in delivered source edges, strobe counts per frame
  always @(posedge sel_clk) n_edge++;
  always @(negedge ref_clk) begin
    n_samp += int'(sample_strobe === 1'b1);
    n_add += int'(sample_strobe === 1'b1 && accumulate_enable === 1'b1);
    n_shf += int'(sample_strobe === 1'b1 && shift_enable === 1'b1);
    n_done += int'(frame_done === 1'b1);
    if (chk && frame_start_pulse === 1'b1 && pulse_d === 1'b0) begin
      // the stretched frame ends one full period after the sample that took the tick
      if (rises > 0 && e_t >= 0) begin
        check(n_edge - e_t, (frame_mult_m1 + 1) * UNIT + 1);
        check(n_done - d_r, 1);
        e_t = -1;
        after_t = 1;
      end else if (rises > 0) begin
        check(n_edge - e_r, (frame_mult_m1 + 1) * UNIT);
        if (!after_t) begin
          check(n_add - a_r, ((frame_mult_m1 + 1) * UNIT) >> add_exp);
          check(n_shf - s_r, ((frame_mult_m1 + 1) * UNIT) >> shift_exp);
        end
        after_t = 0;
        check(n_done - d_r, 1);
      end
      rises++;
      e_r = n_edge;
      a_r = n_add;
      s_r = n_shf;
      d_r = n_done;
    end
    if (chk && rises > 0 && frame_start_pulse === 1'b0 && pulse_d === 1'b1) begin
      check(n_edge - e_r, PLEN);
      check(accumulate_enable, 1);
      check(shift_enable, 1);
    end
    pulse_d = frame_start_pulse;
  end
  // ----
  // scenarios
  // ----
  task automatic t_idle();
    check({frame_start_pulse, accumulate_enable, shift_enable, capture_grant, frame_done, mux_valid, mux_data}, 0);
    run = 3'h1;
    repeat (80) tick1();
    check(n_samp, 0);
  endtask : t_idle
  task automatic t_formatter();
    correlate_req = 1'b1;
    setup(2'h0, 8'h01, 3'h2, 3'h0);
    wait_frames(3);
    capture_req = 1'b1;
    repeat (20) tick1();
    check(capture_grant, 0);
    capture_req = 1'b0;
    next_samp();
    check(mux_valid, 4'hF);
  endtask : t_formatter
  task automatic t_state();
    logic [3:0] seen;
    seen = 4'h0;
    tick1();
    state_count = 1'b1;
    repeat (40) tick1();
    repeat (12) begin
      next_samp();
      check(mux_data, {4{mux_data[1:0]}});
      check($countones(mux_valid), 1);
      seen = seen | mux_valid;
    end
    check(seen, 4'hF);
    tick1();
    state_count = 1'b0;
  endtask : t_state
  // a tick in mid-frame must not shorten the running frame
  task automatic t_track(input int idx);
    run[idx] = 1'b1;
    for (int m = 0; m < 2; m++) begin
      magnitude_level = m[0];
      setup(idx[1:0], 8'h00, 3'(m), 3'h3);
      wait_frames(1);
      repeat (30) tick1();
      // tick placed mid-bit so the next delivered edge is the one that takes it
      @(posedge sel_clk);
      #100;
      e_t = n_edge;
      tick_req[idx] = 1'b1;
      wait_frames(3);
      tick_req[idx] = 1'b0;
      next_samp();
      check(mux_data[0], m[0]);
      check(mux_valid, 4'h1);
    end
  endtask : t_track
  initial begin
    #1000000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    t_idle();
    t_formatter();
    t_state();
    t_track(1);
    t_track(2);
    end_sim();
  end
endmodule : tb
